/* odslp_fifo.sv */
`timescale 1ns/100ps
module odslp_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic         clk,
  input wire logic         rst,
  // both sides
  odslp_fifo_if.store      port
);
  // pointers carry one extra wrap bit; depth must be a power of two
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0]                 wr;
    logic [PW:0]                 rd;
  } odslp_fifo_s;

  odslp_fifo_s st;
  odslp_fifo_s nxt;
  logic        full;
  logic        empty;

  assign full           = (st.wr - st.rd) == (PW+1)'(DEPTH);
  assign empty          = st.wr == st.rd;
  assign port.in_ready  = !full;
  assign port.out_valid = !empty;
  assign port.out_data  = st.mem[st.rd[PW-1:0]];

  always_comb begin
    nxt = st;
    if (rst) begin
      nxt = '0;
    end else begin
      if (port.in_valid && !full) begin
        nxt.mem[st.wr[PW-1:0]] = port.in_data;
        nxt.wr                 = st.wr + 1'b1;
      end
      if (port.out_ready && !empty) begin
        nxt.rd = st.rd + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    st <= nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fifo_no_overrun: assert property (full |=> (st.wr == $past(st.wr)))
    else $error("fifo write pointer moved while full");
endmodule : odslp_fifo

/* odslp_fifo_if.sv */
`timescale 1ns/100ps
interface odslp_fifo_if #(parameter int W = 15);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport store  (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport client (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : odslp_fifo_if

/* odslp_host_model.sv */
`timescale 1ns/100ps
module odslp_host_model (
  // system clock
  input  wire logic CLK,
  // serial pins toward the device
  output logic      frame_sync_n,
  output logic      serial_clock_in,
  output logic      serial_data_in,
  // pass-through bits from the device
  input  wire logic serial_data_out
);
  // serial clock idles low and stands still outside frames
  initial begin
    frame_sync_n    = 1'b1;
    serial_clock_in = 1'b0;
    serial_data_in  = 1'b0;
  end

  task automatic frame(input logic lvl);
    @(posedge CLK);
    frame_sync_n <= lvl;
    // released line has no pull, so never leave the last bit standing
    if (lvl)
      serial_data_in <= ~serial_data_in;
    repeat (12) @(posedge CLK);
  endtask : frame

  // 25 cycles a bit gives the 125 ns link period; data launched on rise, held over the fall
  task automatic send_bits(input logic [15:0] w, input int n, output logic [15:0] echo);
    for (int i = 15; i > 15 - n; i--) begin
      @(posedge CLK);
      echo[i] = serial_data_out;
      serial_clock_in <= ~serial_clock_in;
      serial_data_in  <= w[i];
      repeat (12) @(posedge CLK);
      serial_clock_in <= ~serial_clock_in;
      repeat (12) @(posedge CLK);
    end
  endtask : send_bits
endmodule : odslp_host_model

/* odslp_pkg.sv */
package odslp_pkg;
  // serial word
  localparam int WORD_BITS      = 16;
  localparam int CH_NUM         = 8;
  localparam int CODE_W         = 12;
  localparam int CHAN_W         = 3;
  localparam int DATA_LSB       = 4;
  localparam int ADDR_MATCH_BIT = 3;
  localparam int CHAN_LSB       = 0;
  localparam int FIFO_W         = CHAN_W + CODE_W;
  localparam int FIFO_DEPTH     = 8;
  localparam logic [3:0] LAST_BIT_CNT = 4'hF;

  // pin vector positions, idle levels after reset
  localparam int PIN_NUM  = 6;
  localparam int PIN_SCLK = 0;
  localparam int PIN_FS   = 1;
  localparam int PIN_SDI  = 2;
  localparam int PIN_LOAD_OUTPUTS_N = 3;
  localparam int PIN_CLR  = 4;
  localparam int PIN_ADDR = 5;
  localparam logic [PIN_NUM-1:0] PIN_RST = 6'h1A;

  // register map, byte addresses
  localparam int AXI_AW = 7;
  localparam logic [AXI_AW-1:0] OFS_CTRL   = 7'h00;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 7'h04;
  localparam logic [AXI_AW-1:0] OFS_LAST   = 7'h08;
  localparam logic [AXI_AW-1:0] OFS_INPUT  = 7'h20;
  localparam logic [AXI_AW-1:0] OFS_DAC    = 7'h40;

  // control fields and reset values
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam logic CTRL_EN_RST   = 1'b1;
  localparam logic CTRL_HOLD_RST = 1'b0;

  // status fields
  localparam int ST_OVF_BIT   = 0;
  localparam int ST_EMPTY_BIT = 1;
  localparam int ST_FRAME_BIT = 2;
  localparam int ST_ADDR_BIT  = 3;
  localparam int ST_CNT_LSB   = 4;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : odslp_pkg

/* odslp_top.sv */
// Summary of operation
// - data sampled on serial clock falling edges
// - first bit shifted in is word MSB
// - load low copies input registers to outputs
// - word accepted only when address bit matches pin
// - serial output passes bits through shift register
// - writes only while frame sync held low; input registers take buffered words at any frame sync level
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module odslp_top #(
  parameter int FIFO_DEPTH = odslp_pkg::FIFO_DEPTH
) (
  // system
  input  wire logic                                              CLK,
  input  wire logic                                              RST,
  // serial load pins
  input  wire logic                                              FRAME_SYNC_N,
  input  wire logic                                              SERIAL_CLOCK_IN,
  input  wire logic                                              SERIAL_DATA_IN,
  input  wire logic                                              DEVICE_ADDRESS_PIN,
  input  wire logic                                              LOAD_OUTPUTS_N,
  input  wire logic                                              CLEAR_ALL_N,
  output logic                                                   SERIAL_DATA_OUT,
  // converter codes, channel 0 in the low bits
  output logic [odslp_pkg::CH_NUM*odslp_pkg::CODE_W-1:0]        DAC_CODE,
  // axi4-lite write
  input  wire logic [odslp_pkg::AXI_AW-1:0]                      S_AXI_AWADDR,
  input  wire logic                                              S_AXI_AWVALID,
  output logic                                                   S_AXI_AWREADY,
  input  wire logic [31:0]                                       S_AXI_WDATA,
  input  wire logic [3:0]                                        S_AXI_WSTRB,
  input  wire logic                                              S_AXI_WVALID,
  output logic                                                   S_AXI_WREADY,
  output logic [1:0]                                             S_AXI_BRESP,
  output logic                                                   S_AXI_BVALID,
  input  wire logic                                              S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [odslp_pkg::AXI_AW-1:0]                      S_AXI_ARADDR,
  input  wire logic                                              S_AXI_ARVALID,
  output logic                                                   S_AXI_ARREADY,
  output logic [31:0]                                            S_AXI_RDATA,
  output logic [1:0]                                             S_AXI_RRESP,
  output logic                                                   S_AXI_RVALID,
  input  wire logic                                              S_AXI_RREADY
);
  localparam int PN = odslp_pkg::PIN_NUM;
  localparam int CW = odslp_pkg::CODE_W;
  localparam int WB = odslp_pkg::WORD_BITS;

  typedef struct packed {
    logic [PN-1:0]                    s0;
    logic [PN-1:0]                    s1;
    logic [PN-1:0]                    s2;
    logic [PN-1:0]                    filt;
    logic [WB-1:0]                    shreg;
    logic [3:0]                       bitcnt;
    logic [WB-1:0]                    last_word;
    logic                             en;
    logic                             hold;
    logic                             ovf;
    logic                             push_valid;
    logic [odslp_pkg::FIFO_W-1:0]     push_data;
    logic [odslp_pkg::CH_NUM-1:0][CW-1:0] inreg;
    logic [odslp_pkg::CH_NUM-1:0][CW-1:0] dacreg;
    logic                             aw_got;
    logic                             w_got;
    logic [odslp_pkg::AXI_AW-1:0]     awaddr;
    logic [31:0]                      wdata;
    logic [3:0]                       wstrb;
    logic                             awready;
    logic                             wready;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             arready;
    logic                             rvalid;
    logic [31:0]                      rdata;
    logic [1:0]                       rresp;
  } odslp_state_s;

  odslp_state_s                    st;
  odslp_state_s                    nxt;
  logic [PN-1:0]                   pins;
  logic [PN-1:0]                   stable;
  logic                            sclk_fall;
  logic                            frame_act;
  logic                            sdi_now;
  logic                            clr_low;
  logic                            load_outputs_n_low;
  logic [WB-1:0]                   shift_exp;
  logic                            word_done;
  logic                            match;
  logic                            pop;
  logic [odslp_pkg::CHAN_W-1:0]    pop_chan;
  logic [CW-1:0]                   pop_code;

  odslp_fifo_if #(.W(odslp_pkg::FIFO_W)) fifo_port ();

  odslp_fifo #(
    .WIDTH (odslp_pkg::FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk  (CLK),
    .rst  (RST),
    .port (fifo_port)
  );

  assign pins[odslp_pkg::PIN_SCLK] = SERIAL_CLOCK_IN;
  assign pins[odslp_pkg::PIN_FS]   = FRAME_SYNC_N;
  assign pins[odslp_pkg::PIN_SDI]  = SERIAL_DATA_IN;
  assign pins[odslp_pkg::PIN_LOAD_OUTPUTS_N] = LOAD_OUTPUTS_N;
  assign pins[odslp_pkg::PIN_CLR]  = CLEAR_ALL_N;
  assign pins[odslp_pkg::PIN_ADDR] = DEVICE_ADDRESS_PIN;

  // a pin level counts once the second and third stages agree
  assign stable    = ~(st.s1 ^ st.s2);
  assign sclk_fall = st.filt[odslp_pkg::PIN_SCLK] & stable[odslp_pkg::PIN_SCLK] & ~st.s2[odslp_pkg::PIN_SCLK];
  assign frame_act = ~st.filt[odslp_pkg::PIN_FS];
  assign sdi_now   = stable[odslp_pkg::PIN_SDI] ? st.s2[odslp_pkg::PIN_SDI] : st.filt[odslp_pkg::PIN_SDI];
  assign clr_low   = ~st.filt[odslp_pkg::PIN_CLR];
  assign load_outputs_n_low  = ~st.filt[odslp_pkg::PIN_LOAD_OUTPUTS_N];
  assign shift_exp = {st.shreg[WB-2:0], sdi_now};
  assign word_done = sclk_fall & frame_act & (st.bitcnt == odslp_pkg::LAST_BIT_CNT);
  assign match     = shift_exp[odslp_pkg::ADDR_MATCH_BIT] == st.filt[odslp_pkg::PIN_ADDR];

  // drain stalls on hold so the buffer really fills
  assign fifo_port.in_valid  = st.push_valid;
  assign fifo_port.in_data   = st.push_data;
  assign fifo_port.out_ready = ~st.hold & ~clr_low;
  assign pop      = fifo_port.out_valid & fifo_port.out_ready;
  assign pop_chan = fifo_port.out_data[odslp_pkg::FIFO_W-1 -: odslp_pkg::CHAN_W];
  assign pop_code = fifo_port.out_data[CW-1:0];

  assign SERIAL_DATA_OUT = st.shreg[WB-1];
  assign DAC_CODE        = st.dacreg;
  assign S_AXI_AWREADY   = st.awready;
  assign S_AXI_WREADY    = st.wready;
  assign S_AXI_BVALID    = st.bvalid;
  assign S_AXI_BRESP     = st.bresp;
  assign S_AXI_ARREADY   = st.arready;
  assign S_AXI_RVALID    = st.rvalid;
  assign S_AXI_RDATA     = st.rdata;
  assign S_AXI_RRESP     = st.rresp;

  always_comb begin
    nxt = st;
    if (RST) begin
      nxt      = '0;
      nxt.s0   = odslp_pkg::PIN_RST;
      nxt.s1   = odslp_pkg::PIN_RST;
      nxt.s2   = odslp_pkg::PIN_RST;
      nxt.filt = odslp_pkg::PIN_RST;
      nxt.en   = odslp_pkg::CTRL_EN_RST;
      nxt.hold = odslp_pkg::CTRL_HOLD_RST;
    end else begin
      nxt.s0   = pins;
      nxt.s1   = st.s0;
      nxt.s2   = st.s1;
      nxt.filt = (st.filt & ~stable) | (st.s2 & stable);

      // register writes; clear of the overflow flag comes first so a new overflow wins
      if (st.bvalid && S_AXI_BREADY) begin
        nxt.bvalid = 1'b0;
      end
      if (S_AXI_AWVALID && st.awready) begin
        nxt.aw_got = 1'b1;
        nxt.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && st.wready) begin
        nxt.w_got = 1'b1;
        nxt.wdata = S_AXI_WDATA;
        nxt.wstrb = S_AXI_WSTRB;
      end
      if (st.aw_got && st.w_got && !st.bvalid) begin
        nxt.aw_got = 1'b0;
        nxt.w_got  = 1'b0;
        nxt.bvalid = 1'b1;
        nxt.bresp  = odslp_pkg::RESP_OKAY;
        if ({st.awaddr[odslp_pkg::AXI_AW-1:2], 2'h0} == odslp_pkg::OFS_CTRL) begin
          if (st.wstrb[0]) begin
            nxt.en   = st.wdata[odslp_pkg::CTRL_EN_BIT];
            nxt.hold = st.wdata[odslp_pkg::CTRL_HOLD_BIT];
          end
        end else if ({st.awaddr[odslp_pkg::AXI_AW-1:2], 2'h0} == odslp_pkg::OFS_STATUS) begin
          if (st.wstrb[0] && st.wdata[odslp_pkg::ST_OVF_BIT]) begin
            nxt.ovf = 1'b0;
          end
        end else begin
          nxt.bresp = odslp_pkg::RESP_SLVERR;
        end
      end
      nxt.awready = !nxt.aw_got && !nxt.bvalid;
      nxt.wready  = !nxt.w_got && !nxt.bvalid;

      // register reads
      if (st.rvalid && S_AXI_RREADY) begin
        nxt.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && st.arready) begin
        nxt.rvalid = 1'b1;
        nxt.rdata  = 32'h0000_0000;
        nxt.rresp  = odslp_pkg::RESP_OKAY;
        if ({S_AXI_ARADDR[odslp_pkg::AXI_AW-1:2], 2'h0} == odslp_pkg::OFS_CTRL) begin
          nxt.rdata[odslp_pkg::CTRL_EN_BIT]   = st.en;
          nxt.rdata[odslp_pkg::CTRL_HOLD_BIT] = st.hold;
        end else if ({S_AXI_ARADDR[odslp_pkg::AXI_AW-1:2], 2'h0} == odslp_pkg::OFS_STATUS) begin
          nxt.rdata[odslp_pkg::ST_OVF_BIT]          = st.ovf;
          nxt.rdata[odslp_pkg::ST_EMPTY_BIT]        = ~fifo_port.out_valid;
          nxt.rdata[odslp_pkg::ST_FRAME_BIT]        = frame_act;
          nxt.rdata[odslp_pkg::ST_ADDR_BIT]         = st.filt[odslp_pkg::PIN_ADDR];
          nxt.rdata[odslp_pkg::ST_CNT_LSB +: 4]     = st.bitcnt;
        end else if ({S_AXI_ARADDR[odslp_pkg::AXI_AW-1:2], 2'h0} == odslp_pkg::OFS_LAST) begin
          nxt.rdata[WB-1:0] = st.last_word;
        end else if (S_AXI_ARADDR[odslp_pkg::AXI_AW-1:5] == odslp_pkg::OFS_INPUT[odslp_pkg::AXI_AW-1:5]) begin
          nxt.rdata[CW-1:0] = st.inreg[S_AXI_ARADDR[4:2]];
        end else if (S_AXI_ARADDR[odslp_pkg::AXI_AW-1:5] == odslp_pkg::OFS_DAC[odslp_pkg::AXI_AW-1:5]) begin
          nxt.rdata[CW-1:0] = st.dacreg[S_AXI_ARADDR[4:2]];
        end else begin
          nxt.rresp = odslp_pkg::RESP_SLVERR;
        end
      end
      nxt.arready = !nxt.rvalid;

      // serial shift; frame sync high parks the bit counter
      nxt.push_valid = 1'b0;
      if (!frame_act) begin
        nxt.bitcnt = 4'h0;
      end else if (sclk_fall) begin
        nxt.shreg  = shift_exp;
        nxt.bitcnt = st.bitcnt + 4'h1;
        if (word_done) begin
          nxt.last_word = shift_exp;
          if (match && st.en) begin
            if (fifo_port.in_ready) begin
              nxt.push_valid = 1'b1;
              nxt.push_data  = {shift_exp[odslp_pkg::CHAN_LSB +: odslp_pkg::CHAN_W],
                                shift_exp[odslp_pkg::DATA_LSB +: CW]};
            end else begin
              nxt.ovf = 1'b1;
            end
          end
        end
      end

      // clear dominates both the drain and the load
      if (clr_low) begin
        nxt.inreg  = '0;
        nxt.dacreg = '0;
      end else begin
        if (pop) begin
          nxt.inreg[pop_chan] = pop_code;
        end
        if (load_outputs_n_low) begin
          nxt.dacreg = st.inreg;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    st <= nxt;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_word_ok;
    word_done ##0 (match && st.en && fifo_port.in_ready);
  endsequence

  sequence s_pop;
    pop && !clr_low;
  endsequence

  a_falling_sample: assert property (sclk_fall && frame_act |=> st.shreg == $past(shift_exp))
    else $error("shift register did not take the falling-edge bit");

  a_msb_first: assert property (word_done |=> st.last_word[WB-1] == $past(st.shreg[WB-2]))
    else $error("first bit of the word is not the msb");

  a_load_copy: assert property (load_outputs_n_low && !clr_low |=> st.dacreg == $past(st.inreg))
    else $error("load did not copy input registers");

  a_addr_reject: assert property (word_done && !match |=> !st.push_valid)
    else $error("word with wrong address bit accepted");

  a_addr_accept: assert property (s_word_ok |=> st.push_valid ##1 !st.push_valid)
    else $error("matching word not pushed exactly once");

  a_serial_data_out_pass: assert property (sclk_fall && frame_act |=> SERIAL_DATA_OUT == $past(st.shreg[WB-2]))
    else $error("serial output did not advance with the shift");

  a_frame_gate: assert property (!frame_act |=> st.bitcnt == 4'h0 && st.shreg == $past(st.shreg))
    else $error("shifting outside a frame");

  a_chan_write: assert property (s_pop |=> st.inreg[$past(pop_chan)] == $past(pop_code))
    else $error("channel input register not written");

  a_clear_zero: assert property (clr_low |=> st.inreg == '0 && st.dacreg == '0)
    else $error("clear did not zero the registers");
endmodule : odslp_top

/* testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic        clk, rst, fs_n, sclk, sdi, sdo, addr_pin, load_n, clear_n;
  logic [95:0] dac_code;
  logic [6:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [15:0] echo, prev_w;
  logic        en_m, hold_m, ovf_m;
  logic [15:0] q[$];
  int          failures, n_checks, seed, in_m[8], dac_m[8];

  odslp_top #(.FIFO_DEPTH(8)) odslp_top_inst (
    .CLK(clk), .RST(rst), .FRAME_SYNC_N(fs_n), .SERIAL_CLOCK_IN(sclk), .SERIAL_DATA_IN(sdi),
    .DEVICE_ADDRESS_PIN(addr_pin), .LOAD_OUTPUTS_N(load_n), .CLEAR_ALL_N(clear_n), .SERIAL_DATA_OUT(sdo),
    .DAC_CODE(dac_code), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  odslp_host_model odslp_host_model_inst (
    .CLK(clk), .frame_sync_n(fs_n), .serial_clock_in(sclk), .serial_data_in(sdi), .serial_data_out(sdo));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic axi_wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 200);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
    if (k >= 200) begin
      failures++;
      finish_test();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [6:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (k >= 200) begin
      failures++;
      finish_test();
    end
  endtask : axi_rd

  task automatic drain;
    logic [15:0] w;
    while (q.size() > 0) begin
      w = q.pop_front();
      in_m[w[2:0]] = int'(w[15:4]);
    end
  endtask : drain

  // one word on the link; ck compares the pass-through bits with the word before
  task automatic word(input int ch, input int code, input logic ab, input logic ck);
    logic [15:0] w;
    w = {code[11:0], ab, ch[2:0]};
    odslp_host_model_inst.send_bits(w, 16, echo);
    if (ck)
      check(32'(echo), 32'(prev_w));
    prev_w = w;
    if (ab === addr_pin && en_m) begin
      if (q.size() < 8)
        q.push_back(w);
      else
        ovf_m = 1'b1;
    end
    if (!hold_m)
      drain();
  endtask : word

  task automatic check_regs;
    repeat (10) @(posedge clk);
    for (int n = 0; n < 8; n++) begin
      axi_rd(odslp_pkg::OFS_INPUT + 7'(4 * n), rd, rs);
      check(rd, in_m[n]);
      check(32'(dac_code[12 * n +: 12]), dac_m[n]);
    end
    axi_rd(odslp_pkg::OFS_STATUS, rd, rs);
    check(32'(rd[7:0]), 32'({4'h0, addr_pin, 1'b0, q.size() == 0, ovf_m}));
  endtask : check_regs

  // 0 load, 1 clear, 2 reset; toggles away from the idle level and back
  task automatic pulse(input int which);
    for (int k = 0; k < 2; k++) begin
      case (which)
        0: load_n <= ~load_n;
        1: clear_n <= ~clear_n;
        default: rst <= ~rst;
      endcase
      repeat (8) @(posedge clk);
    end
  endtask : pulse

  initial begin
    {failures, n_checks, seed} = {32'd0, 32'd0, 32'd62303};
    {rst, load_n, clear_n, addr_pin, en_m, hold_m, ovf_m, prev_w} = {7'b1110100, 16'h0};
    {awaddr, araddr, wdata, wstrb} = {7'h0, 7'h0, 32'h0, 4'hF};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    repeat (2) @(posedge clk);
    rst <= ~rst;
    repeat (6) @(posedge clk);
    axi_rd(odslp_pkg::OFS_CTRL, rd, rs);
    check(32'(rd[1:0]), 32'h1);
    axi_rd(7'h10, rd, rs);
    check(32'(rs), 32'(odslp_pkg::RESP_SLVERR));
    axi_wr(odslp_pkg::OFS_INPUT, 32'h5, odslp_pkg::RESP_SLVERR);
    // byte lane 0 off leaves control untouched
    wstrb <= 4'($random(seed)) & 4'hE;
    axi_wr(odslp_pkg::OFS_CTRL, 32'h2, odslp_pkg::RESP_OKAY);
    axi_rd(odslp_pkg::OFS_CTRL, rd, rs);
    check(32'(rd[1:0]), 32'h1);
    wstrb <= 4'($random(seed)) | 4'h1;
    // every channel, then a word for the other address level
    odslp_host_model_inst.frame(1'b0);
    for (int n = 0; n < 8; n++)
      word(n, $random(seed), 1'b0, n > 0);
    word(2, $random(seed), 1'b1, 1'b1);
    odslp_host_model_inst.frame(1'b1);
    check_regs();
    pulse(0);
    for (int n = 0; n < 8; n++)
      dac_m[n] = in_m[n];
    check_regs();
    // other pin level; first word repeated as a chain would need
    addr_pin <= ~addr_pin;
    repeat (8) @(posedge clk);
    odslp_host_model_inst.frame(1'b0);
    word(3, 32'h0A5, 1'b1, 1'b0);
    word(3, 32'h0A5, 1'b1, 1'b1);
    word(4, $random(seed), 1'b0, 1'b1);
    odslp_host_model_inst.send_bits(16'hFFFF, 8, echo);
    odslp_host_model_inst.frame(1'b1);
    odslp_host_model_inst.frame(1'b0);
    word(6, $random(seed), 1'b1, 1'b0);
    odslp_host_model_inst.frame(1'b1);
    check_regs();
    // disabled words dropped; upper write bits ignored
    axi_wr(odslp_pkg::OFS_CTRL, 32'h0, odslp_pkg::RESP_OKAY);
    en_m = 1'b0;
    odslp_host_model_inst.frame(1'b0);
    word(7, $random(seed), 1'b1, 1'b0);
    odslp_host_model_inst.frame(1'b1);
    axi_wr(odslp_pkg::OFS_CTRL, (32'($random(seed)) & 32'hFFFF_FFFC) | 32'h3, odslp_pkg::RESP_OKAY);
    {en_m, hold_m} = 2'b11;
    // nine words into the stalled eight-word buffer
    odslp_host_model_inst.frame(1'b0);
    for (int n = 0; n < 9; n++)
      word(n % 8, $random(seed), 1'b1, n > 0);
    odslp_host_model_inst.frame(1'b1);
    check_regs();
    axi_wr(odslp_pkg::OFS_CTRL, 32'h1, odslp_pkg::RESP_OKAY);
    hold_m = 1'b0;
    drain();
    check_regs();
    axi_wr(odslp_pkg::OFS_STATUS, 32'h1, odslp_pkg::RESP_OKAY);
    ovf_m = 1'b0;
    pulse(0);
    for (int n = 0; n < 8; n++)
      dac_m[n] = in_m[n];
    check_regs();
    // mid-run reset brings back control and register reset values
    axi_wr(odslp_pkg::OFS_CTRL, 32'h2, odslp_pkg::RESP_OKAY);
    pulse(2);
    {en_m, hold_m} = 2'b10;
    for (int n = 0; n < 8; n++)
      {in_m[n], dac_m[n]} = 64'h0;
    axi_rd(odslp_pkg::OFS_CTRL, rd, rs);
    check(32'(rd[1:0]), 32'h1);
    check_regs();
    // one loaded word so the clear has something to zero
    odslp_host_model_inst.frame(1'b0);
    word(5, $random(seed) | 1, 1'b1, 1'b0);
    odslp_host_model_inst.frame(1'b1);
    pulse(0);
    dac_m[5] = in_m[5];
    check_regs();
    pulse(1);
    for (int n = 0; n < 8; n++)
      {in_m[n], dac_m[n]} = 64'h0;
    check_regs();
    finish_test();
  end
endmodule : testbench
